// ---- hw/pgds_pkg.sv ----
// shared constants for the power-good delay, shutdown and sleep-level register slice
// assumes a 40 MHz system clock; used by the register slice and its delay timer
package pgds_pkg;
	// register offsets on the register port
	localparam logic [7:0] OFS_PG_DELAY = 8'h43;
	localparam logic [7:0] OFS_SHUTDOWN = 8'h91;
	localparam logic [7:0] OFS_RAIL_A_SLP = 8'h92;
	localparam logic [7:0] OFS_RAIL_B_SLP = 8'h93;
	// field positions
	localparam int DLY_MSB = 2;
	localparam int FORCE_SHUTDOWN_CMD_BIT = 0;
	localparam int LEVEL_MSB = 7;
	localparam int LEVEL_LSB = 1;
	localparam int SLP_EN_BIT = 0;
	// values after reset
	localparam logic [2:0] RST_PG_DELAY = 3'h0;
	localparam logic [7:0] RST_SHUTDOWN = 8'h00;
	localparam logic [7:0] RST_RAIL_A_SLP = 8'h00;
	localparam logic [7:0] RST_RAIL_B_SLP = 8'h00;
	// delay table in microseconds, converted to cycles at the clock rate
	localparam int unsigned CLK_MHZ = 40;
	localparam int CNT_W = 22;
	localparam int unsigned DELAY_US [8] = '{2500, 5000, 10000, 15000, 20000, 50000, 75000, 100000};
	localparam int unsigned DELAY_CYC [8] = '{DELAY_US[0] * CLK_MHZ, DELAY_US[1] * CLK_MHZ,
		DELAY_US[2] * CLK_MHZ, DELAY_US[3] * CLK_MHZ, DELAY_US[4] * CLK_MHZ,
		DELAY_US[5] * CLK_MHZ, DELAY_US[6] * CLK_MHZ, DELAY_US[7] * CLK_MHZ};
	// which sleep pin a regulator listens to, fixed at build time
	typedef enum logic {PIN_FIRST, PIN_SECOND} pgds_pin_sel_t;
endpackage

// ---- hw/pgds_pg_if.sv ----
// carrier between the register slice and the power-good delay timer
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface pgds_pg_if;
	import pgds_pkg::*;
	logic all_good;
	logic [CNT_W-1:0] limit;
	logic done;
	modport ctrl (output all_good, output limit, input done);
	modport timer (input all_good, input limit, output done);
endinterface

// ---- hw/pgds_pg_timer.sv ----
// power-good delay counter: counts while all grouped rails are good
// assumes all_good is already synchronised and limit is at least one
`timescale 1ns/100ps
module pgds_pg_timer
	import pgds_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// link to the register slice
	pgds_pg_if.timer pg
);
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic done_ff, nxt_done;

	// restart on any rail dropout, hold done once the delay has elapsed
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_done = done_ff;
		if (!pg.all_good) begin
			nxt_cnt = '0;
			nxt_done = 1'b0;
		end else if (!done_ff) begin
			if (cnt_ff >= pg.limit - CNT_W'(1)) begin
				nxt_done = 1'b1;
			end else begin
				nxt_cnt = cnt_ff + CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= '0;
			done_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			done_ff <= nxt_done;
		end
	end

	assign pg.done = done_ff;

	a_done_after_count: assert property (@(posedge clk) disable iff (rst)
		$rose(done_ff) |-> $past(cnt_ff) == $past(pg.limit) - CNT_W'(1) && $past(pg.all_good))
		else $error("delay done before the full count");
	a_dropout_clears: assert property (@(posedge clk) disable iff (rst)
		!pg.all_good |=> !done_ff && cnt_ff == '0)
		else $error("rail dropout did not restart the delay");
endmodule // pgds_pg_timer

// ---- hw/pgds_regs.sv ----
// register slice: output power-good delay, forced shutdown, two sleep-level controls
// assumes a byte-wide register port on clk fed by a serial slave engine elsewhere;
// rail-good and sleep pins are asynchronous and synchronised here
// the delay counter sits in its own module behind a small interface
// delays use nominal counts; their spread is left to the clock accuracy
//
// What this block does
// - delay codes map 2.5 to 100 ms
// - delay starts when all grouped rails good
// - host-driven output ignores delay field unless termination use is set
// - shutdown bit forces full register reset
// - shutdown bit clears itself after acting
// - shutdown write with bit 0 set gets no acknowledge
// - shutdown register resets zero, upper bits zero
// - rail A sleep level in bits 7:1
// - rail A sleep level when enabled, pin low
// - rail A sleep pin chosen at build
// - rail B sleep level in bits 7:1
// - rail B sleep level when enabled, pin low
// - rail B sleep pin chosen at build
// - delay code bits 2:0, rest reserved
`timescale 1ns/100ps
module pgds_regs
	import pgds_pkg::*;
#(
	parameter int NUM_RAILS = 4,
	parameter logic [NUM_RAILS-1:0] OUT3_RAIL_MASK = '1,
	parameter pgds_pin_sel_t RAIL_A_PIN = PIN_FIRST,
	parameter pgds_pin_sel_t RAIL_B_PIN = PIN_SECOND,
	parameter int unsigned DELAY_CYCLES [8] = DELAY_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_ack,
	// asynchronous pins
	input wire logic [NUM_RAILS-1:0] rail_good,
	input wire logic sleep_pin_first,
	input wire logic sleep_pin_second,
	// factory and neighbouring register state, same clock
	input wire logic out3_host_mode,
	input wire logic out3_term_use,
	input wire logic out3_host_level,
	input wire logic [6:0] rail_a_normal_level,
	input wire logic [6:0] rail_b_normal_level,
	// outputs to regulators, pin and sequencer
	output logic general_output_three,
	output logic [6:0] rail_a_level,
	output logic [6:0] rail_b_level,
	output logic force_shutdown_cmd
);
	localparam int SYNC_W = NUM_RAILS + 2;

	// refuse delay counts that the counter cannot hold
	for (genvar i = 0; i < 8; i++) begin : g_chk
		if (DELAY_CYCLES[i] == 0 || DELAY_CYCLES[i] >= (64'd1 << CNT_W)) begin : g_bad
			$error("delay cycle count out of range");
		end
	end
	if (NUM_RAILS < 1) begin : g_bad_rails
		$error("need at least one rail");
	end

	// two-stage synchronisers for every pin input
	// the flops reset to 0, so both sleep pins read as a sleep request and every
	// grouped rail as not good until two clocks after reset is released
	logic [SYNC_W-1:0] sync_in;
	logic [SYNC_W-1:0] sync_meta_ff;
	logic [SYNC_W-1:0] sync_ff;
	assign sync_in = {rail_good, sleep_pin_second, sleep_pin_first};
	for (genvar s = 0; s < SYNC_W; s++) begin : g_sync
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				sync_meta_ff[s] <= 1'b0;
				sync_ff[s] <= 1'b0;
			end else begin
				sync_meta_ff[s] <= sync_in[s];
				sync_ff[s] <= sync_meta_ff[s];
			end
		end
	end

	logic pin_first_s, pin_second_s;
	logic [NUM_RAILS-1:0] rail_good_s;
	assign pin_first_s = sync_ff[0];
	assign pin_second_s = sync_ff[1];
	assign rail_good_s = sync_ff[SYNC_W-1:2];

	// register state
	logic [2:0] dly_code_ff, nxt_dly_code;
	logic [7:0] a_slp_ff, nxt_a_slp;
	logic [7:0] b_slp_ff, nxt_b_slp;
	logic force_shutdown_cmd_ff, nxt_force_shutdown_cmd;
	logic [7:0] rdata_ff, nxt_rdata;
	logic ack_ff, nxt_ack;

	logic wr_force_shutdown_cmd, mapped;
	assign wr_force_shutdown_cmd = reg_wr && reg_addr == OFS_SHUTDOWN && reg_wdata[FORCE_SHUTDOWN_CMD_BIT];
	assign mapped = reg_addr == OFS_PG_DELAY || reg_addr == OFS_SHUTDOWN ||
		reg_addr == OFS_RAIL_A_SLP || reg_addr == OFS_RAIL_B_SLP;

	// register writes; a pending shutdown wipes everything and swallows the access
	// the shutdown pulse lasts one cycle and the wipe lands on the edge that ends it,
	// so an access made while the pulse stands is dropped rather than half applied
	always_comb begin
		nxt_dly_code = dly_code_ff;
		nxt_a_slp = a_slp_ff;
		nxt_b_slp = b_slp_ff;
		nxt_force_shutdown_cmd = 1'b0;
		if (force_shutdown_cmd_ff) begin
			nxt_dly_code = RST_PG_DELAY;
			nxt_a_slp = RST_RAIL_A_SLP;
			nxt_b_slp = RST_RAIL_B_SLP;
		end else if (reg_wr) begin
			case (reg_addr)
				OFS_PG_DELAY: nxt_dly_code = reg_wdata[DLY_MSB:0];
				OFS_SHUTDOWN: nxt_force_shutdown_cmd = reg_wdata[FORCE_SHUTDOWN_CMD_BIT];
				OFS_RAIL_A_SLP: nxt_a_slp = reg_wdata;
				OFS_RAIL_B_SLP: nxt_b_slp = reg_wdata;
				default: nxt_force_shutdown_cmd = 1'b0;
			endcase
		end
	end

	// read data and acknowledge; unmapped offsets get no acknowledge
	// read data is zero whenever no acknowledge stands, so a stale byte is never seen
	always_comb begin
		nxt_rdata = 8'h00;
		nxt_ack = 1'b0;
		if (!force_shutdown_cmd_ff) begin
			if (reg_wr) begin
				nxt_ack = mapped && !wr_force_shutdown_cmd;
			end else if (reg_rd) begin
				nxt_ack = mapped;
				case (reg_addr)
					OFS_PG_DELAY: nxt_rdata = {5'h00, dly_code_ff};
					OFS_SHUTDOWN: nxt_rdata = {7'h00, force_shutdown_cmd_ff};
					OFS_RAIL_A_SLP: nxt_rdata = a_slp_ff;
					OFS_RAIL_B_SLP: nxt_rdata = b_slp_ff;
					default: nxt_rdata = 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dly_code_ff <= RST_PG_DELAY;
			a_slp_ff <= RST_RAIL_A_SLP;
			b_slp_ff <= RST_RAIL_B_SLP;
			force_shutdown_cmd_ff <= RST_SHUTDOWN[FORCE_SHUTDOWN_CMD_BIT];
			rdata_ff <= 8'h00;
			ack_ff <= 1'b0;
		end else begin
			dly_code_ff <= nxt_dly_code;
			a_slp_ff <= nxt_a_slp;
			b_slp_ff <= nxt_b_slp;
			force_shutdown_cmd_ff <= nxt_force_shutdown_cmd;
			rdata_ff <= nxt_rdata;
			ack_ff <= nxt_ack;
		end
	end

	assign reg_rdata = rdata_ff;
	assign reg_ack = ack_ff;
	assign force_shutdown_cmd = force_shutdown_cmd_ff;

	// power-good delay timer for the general output
	// the limit follows the stored code at once; a code change in mid-count acts on
	// the running count, so the host should change it only while the rails are down
	pgds_pg_if pg_link ();
	assign pg_link.all_good = &(rail_good_s | ~OUT3_RAIL_MASK);
	assign pg_link.limit = CNT_W'(DELAY_CYCLES[dly_code_ff]);

	pgds_pg_timer u_timer (
		.clk(clk),
		.rst(rst),
		.pg(pg_link.timer)
	);

	// output drive and applied level codes
	// the applied codes are not wiped by shutdown: they follow the wiped sleep
	// registers one cycle later, which keeps a second reset source off the level path
	logic out3_ff, nxt_out3;
	logic [6:0] a_lvl_ff, nxt_a_lvl;
	logic [6:0] b_lvl_ff, nxt_b_lvl;
	logic a_pin_s, b_pin_s, use_delay;

	// pin choice is a build-time strap, so software cannot move it
	assign a_pin_s = (RAIL_A_PIN == PIN_FIRST) ? pin_first_s : pin_second_s;
	assign b_pin_s = (RAIL_B_PIN == PIN_FIRST) ? pin_first_s : pin_second_s;
	// a host-driven pin still needs the delay when it enables the termination regulator
	assign use_delay = !out3_host_mode || out3_term_use;

	always_comb begin
		nxt_out3 = use_delay ? pg_link.done : out3_host_level;
		nxt_a_lvl = rail_a_normal_level;
		nxt_b_lvl = rail_b_normal_level;
		if (a_slp_ff[SLP_EN_BIT] && !a_pin_s) begin
			nxt_a_lvl = a_slp_ff[LEVEL_MSB:LEVEL_LSB];
		end
		if (b_slp_ff[SLP_EN_BIT] && !b_pin_s) begin
			nxt_b_lvl = b_slp_ff[LEVEL_MSB:LEVEL_LSB];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out3_ff <= 1'b0;
			a_lvl_ff <= 7'h00;
			b_lvl_ff <= 7'h00;
		end else begin
			out3_ff <= nxt_out3;
			a_lvl_ff <= nxt_a_lvl;
			b_lvl_ff <= nxt_b_lvl;
		end
	end

	assign general_output_three = out3_ff;
	assign rail_a_level = a_lvl_ff;
	assign rail_b_level = b_lvl_ff;

	// checks on the shutdown command and the reserved delay bits
	a_force_shutdown_cmd_no_ack: assert property (@(posedge clk) disable iff (rst)
		wr_force_shutdown_cmd && !force_shutdown_cmd_ff |=> force_shutdown_cmd_ff && !reg_ack)
		else $error("shutdown write was acknowledged or not taken");
	a_force_shutdown_cmd_self_clear: assert property (@(posedge clk) disable iff (rst)
		force_shutdown_cmd_ff |=> !force_shutdown_cmd_ff)
		else $error("shutdown bit did not clear itself");
	a_force_shutdown_cmd_wipes_regs: assert property (@(posedge clk) disable iff (rst)
		force_shutdown_cmd_ff |=> dly_code_ff == RST_PG_DELAY && a_slp_ff == RST_RAIL_A_SLP &&
			b_slp_ff == RST_RAIL_B_SLP)
		else $error("registers not reset by shutdown");
	a_force_shutdown_cmd_read_zero: assert property (@(posedge clk) disable iff (rst)
		reg_rd && !reg_wr && reg_addr == OFS_SHUTDOWN && !force_shutdown_cmd_ff |=> reg_ack &&
			reg_rdata == 8'h00)
		else $error("shutdown register read not zero");
	a_delay_reserved: assert property (@(posedge clk) disable iff (rst)
		reg_rd && !reg_wr && reg_addr == OFS_PG_DELAY && !force_shutdown_cmd_ff |=> reg_rdata[7:3] == 5'h00)
		else $error("reserved delay bits not zero");

	// checks on register storage, level selection and the general output
	a_rail_a_store: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == OFS_RAIL_A_SLP && !force_shutdown_cmd_ff |=> a_slp_ff == $past(reg_wdata))
		else $error("rail A sleep control not stored");
	a_rail_b_store: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == OFS_RAIL_B_SLP && !force_shutdown_cmd_ff |=> b_slp_ff == $past(reg_wdata))
		else $error("rail B sleep control not stored");
	a_delay_store: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == OFS_PG_DELAY && !force_shutdown_cmd_ff |=>
			dly_code_ff == $past(reg_wdata[DLY_MSB:0]))
		else $error("delay code not stored");
	a_rail_a_select: assert property (@(posedge clk) disable iff (rst)
		a_slp_ff[SLP_EN_BIT] && !a_pin_s |=> rail_a_level == $past(a_slp_ff[7:1]))
		else $error("rail A sleep level not applied");
	a_rail_b_normal: assert property (@(posedge clk) disable iff (rst)
		!b_slp_ff[SLP_EN_BIT] |=> rail_b_level == $past(rail_b_normal_level))
		else $error("rail B normal level not applied");
	a_out3_host: assert property (@(posedge clk) disable iff (rst)
		out3_host_mode && !out3_term_use |=> general_output_three == $past(out3_host_level))
		else $error("host-driven output not followed");
	a_out3_dropout: assert property (@(posedge clk) disable iff (rst)
		use_delay && !pg_link.all_good ##1 use_delay |=> !general_output_three)
		else $error("output held after rail dropout");

	// checks on the applied level codes
	a_rail_a_normal: assert property (@(posedge clk) disable iff (rst)
		!a_slp_ff[SLP_EN_BIT] |=> rail_a_level == $past(rail_a_normal_level))
		else $error("rail A normal level not applied");
	a_rail_a_awake: assert property (@(posedge clk) disable iff (rst)
		a_slp_ff[SLP_EN_BIT] && a_pin_s |=> rail_a_level == $past(rail_a_normal_level))
		else $error("rail A left normal level with its pin high");
	a_rail_b_select: assert property (@(posedge clk) disable iff (rst)
		b_slp_ff[SLP_EN_BIT] && !b_pin_s |=> rail_b_level == $past(b_slp_ff[7:1]))
		else $error("rail B sleep level not applied");
	a_rail_b_awake: assert property (@(posedge clk) disable iff (rst)
		b_slp_ff[SLP_EN_BIT] && b_pin_s |=> rail_b_level == $past(rail_b_normal_level))
		else $error("rail B left normal level with its pin high");

	// checks on the general output, on accesses around shutdown and on delay read-back
	a_out3_term: assert property (@(posedge clk) disable iff (rst)
		out3_term_use |=> general_output_three == $past(pg_link.done))
		else $error("termination use did not keep the delay");
	a_out3_delay_done: assert property (@(posedge clk) disable iff (rst)
		use_delay && pg_link.done |=> general_output_three)
		else $error("output not raised after the delay");
	a_force_shutdown_cmd_drops_access: assert property (@(posedge clk) disable iff (rst)
		force_shutdown_cmd_ff && (reg_wr || reg_rd) |=> !reg_ack)
		else $error("access acknowledged during shutdown");
	a_force_shutdown_cmd_zero_write: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_addr == OFS_SHUTDOWN && !reg_wdata[FORCE_SHUTDOWN_CMD_BIT] && !force_shutdown_cmd_ff |=>
			!force_shutdown_cmd_ff && reg_ack)
		else $error("shutdown write of zero mishandled");
	a_delay_read_back: assert property (@(posedge clk) disable iff (rst)
		reg_rd && !reg_wr && reg_addr == OFS_PG_DELAY && !force_shutdown_cmd_ff |=>
			reg_ack && reg_rdata[DLY_MSB:0] == $past(dly_code_ff))
		else $error("delay code read back wrong");
endmodule // pgds_regs

// ---- bench/pgds_host_model.sv ----
// host side of the register port: one strobed access at a time
// assumes the slice answers on the taking edge; the host reads it at the next falling edge
`timescale 1ns/100ps
module pgds_host_model (
	// clock
	input wire logic clk,
	// register port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_ack
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// drive at the falling edge; idle lines show the inverse so stale data never matches
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic ack, output logic [7:0] q);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = w;
		reg_rd = !w;
		@(negedge clk);
		ack = reg_ack;
		q = reg_rdata;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
endmodule // pgds_host_model

// ---- bench/pgds_regs_tb_top.sv ----
// self-checking bench for the delay, shutdown and sleep-level slice
// assumes shortened delay counts; host model makes every access
`timescale 1ns/100ps
module pgds_regs_tb_top;
	import pgds_pkg::*;
	logic clk = 1'b0, rst = 1'b1, h_mode = 1'b0, h_term = 1'b0, h_lvl = 1'b0;
	logic sp1 = 1'b1, sp2 = 1'b1, ack, fsd, out3, wr_s, rd_s;
	logic [7:0] addr, wdata, rdata, q, ra, rb;
	logic [6:0] lvl_a, lvl_b, nrm_a = 7'h00, nrm_b = 7'h00;
	logic [3:0] good = 4'h0;
	integer seed = 32'h1aed;
	int mismatches, num_checks, cyc, n;
	always #12.5 clk = ~clk;
	pgds_host_model host (.clk(clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s),
		.reg_rd(rd_s), .reg_rdata(rdata), .reg_ack(ack));
	pgds_regs #(.DELAY_CYCLES('{10, 20, 30, 40, 50, 60, 70, 80})) dut (.clk(clk), .rst(rst),
		.reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata),
		.reg_ack(ack), .rail_good(good), .sleep_pin_first(sp1), .sleep_pin_second(sp2),
		.out3_host_mode(h_mode), .out3_term_use(h_term), .out3_host_level(h_lvl),
		.rail_a_normal_level(nrm_a), .rail_b_normal_level(nrm_b),
		.general_output_three(out3), .rail_a_level(lvl_a), .rail_b_level(lvl_b),
		.force_shutdown_cmd(fsd));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// one access; ack always compared, read data only on reads
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic eack, input logic [7:0] eq);
		logic k;
		host.xfer(w, a, d, k, q);
		chk({7'h00, k}, {7'h00, eack});
		if (!w) chk(q, eq);
	endtask
	function automatic logic [7:0] lvl(input logic [7:0] r, input logic pin, input logic [6:0] nv);
		return {1'b0, (r[0] && !pin) ? r[7:1] : nv};
	endfunction
	// hang guard, well above the roughly 700 cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			mismatches++;
			final_report();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		// reset values, reserved bits, unmapped offset, harmless shutdown write
		acc(0, OFS_PG_DELAY, 8'h00, 1, {5'h00, RST_PG_DELAY});
		acc(0, OFS_SHUTDOWN, 8'h00, 1, RST_SHUTDOWN);
		acc(0, 8'h44, 8'h00, 0, 8'h00);
		acc(1, OFS_SHUTDOWN, 8'hFE, 1, 8'h00);
		acc(0, OFS_SHUTDOWN, 8'h00, 1, 8'h00);
		// every enable and pin combination, random levels
		for (int i = 0; i < 8; i++) begin
			ra = 8'($random(seed));
			rb = 8'($random(seed));
			ra[0] = i[0];
			rb[0] = i[0];
			nrm_a = 7'($random(seed));
			nrm_b = 7'($random(seed));
			sp1 = i[1];
			sp2 = i[2];
			acc(1, OFS_RAIL_A_SLP, ra, 1, 8'h00);
			acc(1, OFS_RAIL_B_SLP, rb, 1, 8'h00);
			acc(0, OFS_RAIL_A_SLP, 8'h00, 1, ra);
			acc(0, OFS_RAIL_B_SLP, 8'h00, 1, rb);
			repeat (5) @(negedge clk);
			chk({1'b0, lvl_a}, lvl(ra, sp1, nrm_a));
			chk({1'b0, lvl_b}, lvl(rb, sp2, nrm_b));
		end
		// each delay code timed from the last rail good, then a dropout
		for (int c = 0; c < 8; c++) begin
			good = 4'h7;
			acc(1, OFS_PG_DELAY, {5'h1F, 3'(c)}, 1, 8'h00);
			acc(0, OFS_PG_DELAY, 8'h00, 1, {5'h00, 3'(c)});
			repeat (4) @(negedge clk);
			chk({7'h00, out3}, 8'h00);
			good = 4'hF;
			n = 0;
			while (out3 !== 1'b1 && n < 200) begin
				@(negedge clk);
				n++;
			end
			chk(8'(n >= 10 * c + 11 && n <= 10 * c + 15), 8'h01);
			good[2'($random(seed))] = 1'b0;
			repeat (4) @(negedge clk);
			chk({7'h00, out3}, 8'h00);
			good = 4'hF;
			repeat (6) @(negedge clk);
			chk({7'h00, out3}, 8'h00);
		end
		// host-driven output follows the host level with rails down
		good = 4'h0;
		h_mode = 1'b1;
		h_lvl = 1'b1;
		repeat (3) @(negedge clk);
		chk({7'h00, out3}, 8'h01);
		h_lvl = 1'b0;
		repeat (3) @(negedge clk);
		chk({7'h00, out3}, 8'h00);
		// termination use keeps the delay, so the low rails win over the host level
		h_term = 1'b1;
		h_lvl = 1'b1;
		repeat (3) @(negedge clk);
		chk({7'h00, out3}, 8'h00);
		h_term = 1'b0;
		h_mode = 1'b0;
		// forced shutdown: no ack, one pulse, everything back to reset
		acc(1, OFS_RAIL_A_SLP, 8'hA5, 1, 8'h00);
		acc(1, OFS_RAIL_B_SLP, 8'h5B, 1, 8'h00);
		acc(1, OFS_SHUTDOWN, 8'h01, 0, 8'h00);
		chk({7'h00, fsd}, 8'h01);
		@(negedge clk);
		chk({7'h00, fsd}, 8'h00);
		acc(0, OFS_RAIL_A_SLP, 8'h00, 1, RST_RAIL_A_SLP);
		acc(0, OFS_RAIL_B_SLP, 8'h00, 1, RST_RAIL_B_SLP);
		acc(0, OFS_PG_DELAY, 8'h00, 1, 8'h00);
		acc(0, OFS_SHUTDOWN, 8'h00, 1, 8'h00);
		final_report();
	end
endmodule // pgds_regs_tb_top
